// ### hdl/sspt_pkg.sv
// package of constants shared by both ends of the sensor serial port
// Overview of operation
// - host alone starts every exchange
// - chip select high: ignore inputs, tristate output
// - host always generates the serial clock
// - chip select rise aborts, port goes idle
// - after abort host still keeps usual waits
// - host frames each transaction with chip select
// - write: address byte msb 1, then data
// - sensor samples data on rising clock
// - sensor changes output after falling clock
// - host spaces writes at least 30 us
// - write to read gap at least 20 us
// - after read wait 250 ns
// - read address to data wait 4 us
// - chip select low to first fall 120 ns
// - write: hold select low 20 us after
// - read: hold select low 120 ns after
// - reset register write: motion valid within 50 ms
// - power down bit: low current within 50 ms
// - wake write: motion valid 50 to 55 ms
// - read: address msb 0, sensor returns data
package sspt_pkg;
  localparam int unsigned clk_mhz = 200;
  // timing figures in their own units
  localparam int unsigned t_sww_us = 30;
  localparam int unsigned t_swr_us = 20;
  localparam int unsigned t_srw_ns = 250;
  localparam int unsigned t_srad_us = 4;
  localparam int unsigned t_ncs_sclk_ns = 120;
  localparam int unsigned t_sclk_ncs_wr_us = 20;
  localparam int unsigned t_sclk_ncs_rd_ns = 120;
  localparam int unsigned t_mot_rst_ms = 50;
  localparam int unsigned t_pd_ms = 50;
  localparam int unsigned t_wake_min_ms = 50;
  localparam int unsigned t_wake_max_ms = 55;
  // derived cycle counts, least times rounded up
  localparam int unsigned cyc_sww = t_sww_us * clk_mhz;
  localparam int unsigned cyc_swr = t_swr_us * clk_mhz;
  localparam int unsigned cyc_srw = (t_srw_ns * clk_mhz + 999) / 1000;
  localparam int unsigned cyc_srad = t_srad_us * clk_mhz;
  localparam int unsigned cyc_ncs_sclk =
    (t_ncs_sclk_ns * clk_mhz + 999) / 1000;
  localparam int unsigned cyc_sclk_ncs_wr = t_sclk_ncs_wr_us * clk_mhz;
  localparam int unsigned cyc_sclk_ncs_rd =
    (t_sclk_ncs_rd_ns * clk_mhz + 999) / 1000;
  // longest times rounded down; wake least rounded up
  localparam int unsigned cyc_mot_rst = t_mot_rst_ms * clk_mhz * 1000;
  localparam int unsigned cyc_pd = t_pd_ms * clk_mhz * 1000;
  localparam int unsigned cyc_wake_min = t_wake_min_ms * clk_mhz * 1000;
  localparam int unsigned cyc_wake_max = t_wake_max_ms * clk_mhz * 1000;
  // host serial clock half period: 41 cycles from sclk_half = 40, 410 ns period
  localparam int unsigned sclk_half = 40;
  // register map fields
  localparam logic [6:0] reg_pwr_ctl = 7'h0d;
  localparam logic [6:0] reg_reset = 7'h3a;
  localparam logic [7:0] reset_key = 8'h5a;
  localparam int unsigned pd_bit = 1;
  localparam int unsigned rw_bit = 7;
  localparam logic [2:0] bit_last = 3'h7;
  localparam logic [7:0] reg_rst_val = 8'h00;
endpackage : sspt_pkg

// ### hdl/sspt_if.sv
// interface joining host and sensor ends of the serial port
`timescale 1ns/10ps
interface sspt_if;
  logic sclk;
  logic mosi;
  logic ncs_n;
  logic miso_out;
  logic miso_oe_n;
  modport sensor (
    input sclk,
    input mosi,
    input ncs_n,
    output miso_out,
    output miso_oe_n
  );
  modport host (
    output sclk,
    output mosi,
    output ncs_n,
    input miso_out,
    input miso_oe_n
  );
endinterface : sspt_if

// ### hdl/sspt_sensor.sv
// sensor end: pin synchronisers, serial slave, registers, power sequencing
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////
// two-flop synchroniser for one pin coming from the host's side
module sspt_sync #(
  parameter logic rst_val = 1'b0
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic din,
  output logic dout
);
  import sspt_pkg::*;

  typedef struct packed {
    logic meta;
    logic stable;
  } sspt_sy_t;

  sspt_sy_t st_ff;
  sspt_sy_t nxt_st;

  // only the second stage leaves; the first may still be settling
  always_comb begin
    nxt_st = st_ff;
    nxt_st.meta = din;
    nxt_st.stable = st_ff.meta;
  end

  // reset to the pin's idle level, else a false edge follows reset
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_ff <= {rst_val, rst_val};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dout = st_ff.stable;
endmodule : sspt_sync

//////////////////////////////////////////////////////////////////////
// serial slave end of the link
module sspt_sensor #(
  parameter int unsigned mot_rst_cyc = sspt_pkg::cyc_mot_rst,
  parameter int unsigned pd_cyc = sspt_pkg::cyc_pd,
  parameter int unsigned wake_cyc = sspt_pkg::cyc_wake_min
) (
  input wire logic mclk,
  input wire logic srst,
  sspt_if.sensor bus,
  output logic [6:0] wr_addr,
  output logic [7:0] wr_data,
  output logic wr_stb,
  output logic motion_valid,
  output logic low_power
);
  import sspt_pkg::*;

  typedef enum logic [1:0] {s_run, s_settle, s_pdown} sspt_pwr_t;
  typedef struct packed {
    logic sclk_d;
    logic [2:0] bcnt;
    logic second;
    logic wr;
    logic [6:0] addr;
    logic [7:0] sh;
    logic [7:0] tx;
    logic miso;
    logic oe_n;
    logic [127:0][7:0] regs;
    sspt_pwr_t pwr;
    logic [31:0] tmr;
    logic [6:0] wa;
    logic [7:0] wd;
    logic ws;
    logic mv;
    logic lp;
  } sspt_sen_t;

  sspt_sen_t st_ff;
  sspt_sen_t nxt_st;
  logic sel;
  logic rise;
  logic fall;
  logic [7:0] byte_in;
  logic ncs_s;
  logic sclk_s;
  logic mosi_s;

  // every host pin crosses into mclk through two flops before use
  sspt_sync #(.rst_val(1'b1)) u_sync_ncs (
    .mclk(mclk),
    .srst(srst),
    .din(bus.ncs_n),
    .dout(ncs_s)
  );
  // serial clock idles high, so its stages reset high too
  sspt_sync #(.rst_val(1'b1)) u_sync_sclk (
    .mclk(mclk),
    .srst(srst),
    .din(bus.sclk),
    .dout(sclk_s)
  );
  // data is only looked at on a detected rise
  sspt_sync #(.rst_val(1'b0)) u_sync_mosi (
    .mclk(mclk),
    .srst(srst),
    .din(bus.mosi),
    .dout(mosi_s)
  );

  ////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sclk_d = sclk_s;
    nxt_st.ws = 1'b0;
    sel = ~ncs_s;
    rise = sclk_s & ~st_ff.sclk_d;
    fall = ~sclk_s & st_ff.sclk_d;
    byte_in = {st_ff.sh[6:0], mosi_s};
    if (!sel) begin
      // deselected: port idle, counter back at address bit
      nxt_st.bcnt = 3'h0;
      nxt_st.second = 1'b0;
      nxt_st.oe_n = 1'b1;
    end else begin
      // output only while selected; sensor never starts alone
      nxt_st.oe_n = 1'b0;
      if (rise) begin
        nxt_st.sh = byte_in;
        nxt_st.bcnt = 3'(st_ff.bcnt + 3'h1);
        if (st_ff.bcnt == bit_last) begin
          if (!st_ff.second) begin
            nxt_st.second = 1'b1;
            nxt_st.wr = byte_in[rw_bit];
            nxt_st.addr = byte_in[6:0];
            nxt_st.tx = st_ff.regs[byte_in[6:0]];
          end else begin
            nxt_st.second = 1'b0;
            if (st_ff.wr) begin
              nxt_st.regs[st_ff.addr] = byte_in;
              nxt_st.wa = st_ff.addr;
              nxt_st.wd = byte_in;
              nxt_st.ws = 1'b1;
            end
          end
        end
      end
      // shift out msb first, changing only after a falling edge
      if (fall && st_ff.second && !st_ff.wr) begin
        nxt_st.miso = st_ff.tx[7];
        nxt_st.tx = {st_ff.tx[6:0], 1'b0};
      end
    end
    // power sequencing driven by completed writes
    if (st_ff.tmr != 32'h0) begin
      nxt_st.tmr = st_ff.tmr - 32'h1;
    end
    case (st_ff.pwr)
      s_run: begin
        if (st_ff.ws && st_ff.wa == reg_pwr_ctl && st_ff.wd[pd_bit]) begin
          nxt_st.pwr = s_pdown;
          nxt_st.tmr = 32'(pd_cyc);
          nxt_st.mv = 1'b0;
        end
      end
      s_settle: begin
        if (st_ff.tmr == 32'h1 || st_ff.tmr == 32'h0) begin
          nxt_st.pwr = s_run;
          nxt_st.mv = 1'b1;
        end
      end
      s_pdown: begin
        if (st_ff.tmr == 32'h1) begin
          nxt_st.lp = 1'b1;
        end
      end
      default: begin
        nxt_st.pwr = s_run;
      end
    endcase
    // reset key write from any state restarts motion settling
    if (st_ff.ws && st_ff.wa == reg_reset && st_ff.wd == reset_key) begin
      nxt_st.pwr = s_settle;
      nxt_st.tmr = (st_ff.pwr == s_pdown) ? 32'(wake_cyc) : 32'(mot_rst_cyc);
      nxt_st.mv = 1'b0;
      nxt_st.lp = 1'b0;
      nxt_st.regs = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_ff <= '0;
      st_ff.sclk_d <= 1'b1; // clock idles high, no false rise
      st_ff.oe_n <= 1'b1;
      st_ff.pwr <= s_run;
      st_ff.mv <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bus.miso_out = st_ff.miso;
  assign bus.miso_oe_n = st_ff.oe_n;
  assign wr_addr = st_ff.wa;
  assign wr_data = st_ff.wd;
  assign wr_stb = st_ff.ws;
  assign motion_valid = st_ff.mv;
  assign low_power = st_ff.lp;
endmodule : sspt_sensor

// ### hdl/sspt_host.sv
// host end: serial master running one framed read or write per request
`timescale 1ns/10ps
module sspt_host (
  input wire logic mclk,
  input wire logic srst,
  sspt_if.host bus,
  input wire logic req,
  input wire logic req_wr,
  input wire logic [6:0] req_addr,
  input wire logic [7:0] req_data,
  output logic busy,
  output logic done,
  output logic [7:0] rd_data
);
  import sspt_pkg::*;

  typedef enum logic [2:0] {h_idle, h_lead, h_bits, h_srad, h_tail,
    h_gap} sspt_hst_t;
  typedef struct packed {
    sspt_hst_t st;
    logic [1:0] miso_sy;
    logic [31:0] cnt;
    logic [31:0] gap;
    logic [3:0] bit_n;
    logic second;
    logic wr;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] rx;
    logic sclk;
    logic mosi;
    logic ncs_n;
    logic busy;
    logic done;
  } sspt_hs_t;

  sspt_hs_t st_ff;
  sspt_hs_t nxt_st;

  ////////////////////////////////////////////////////////////////////
  // master sequencer; serial clock divided from mclk
  always_comb begin
    nxt_st = st_ff;
    nxt_st.miso_sy = {st_ff.miso_sy[0], bus.miso_out};
    nxt_st.done = 1'b0;
    if (st_ff.cnt != 32'h0) begin
      nxt_st.cnt = st_ff.cnt - 32'h1;
    end
    case (st_ff.st)
      h_idle: begin
        if (req) begin
          nxt_st.st = h_lead;
          nxt_st.ncs_n = 1'b0;
          nxt_st.busy = 1'b1;
          nxt_st.wr = req_wr;
          nxt_st.a = {req_wr, req_addr};
          nxt_st.d = req_data;
          nxt_st.mosi = req_wr;
          nxt_st.second = 1'b0;
          nxt_st.bit_n = 4'h0;
          nxt_st.cnt = 32'(cyc_ncs_sclk);
        end
      end
      h_lead: begin
        if (st_ff.cnt == 32'h0) begin
          nxt_st.st = h_bits;
          nxt_st.sclk = 1'b0;
          nxt_st.cnt = 32'(sclk_half);
        end
      end
      h_bits: begin
        if (st_ff.cnt == 32'h0) begin
          nxt_st.cnt = 32'(sclk_half);
          nxt_st.sclk = ~st_ff.sclk;
          if (!st_ff.sclk) begin
            // rising edge: sample sensor data msb first
            nxt_st.rx = {st_ff.rx[6:0], st_ff.miso_sy[1]};
            nxt_st.bit_n = 4'(st_ff.bit_n + 4'h1);
            if (st_ff.bit_n == 4'h7) begin
              nxt_st.bit_n = 4'h0;
              if (!st_ff.second) begin
                nxt_st.second = 1'b1;
                nxt_st.st = st_ff.wr ? h_bits : h_srad;
                nxt_st.cnt = st_ff.wr ? 32'(sclk_half) : 32'(cyc_srad);
              end else begin
                nxt_st.st = h_tail;
                nxt_st.cnt = st_ff.wr ? 32'(cyc_sclk_ncs_wr)
                  : 32'(cyc_sclk_ncs_rd);
                nxt_st.gap = st_ff.wr ? 32'(cyc_sww)
                  : 32'(cyc_srw);
              end
            end
          end else begin
            // falling edge: present next bit msb first
            nxt_st.mosi = st_ff.second ? st_ff.d[3'(7 - st_ff.bit_n)]
              : st_ff.a[3'(7 - st_ff.bit_n)];
          end
        end
      end
      h_srad: begin
        if (st_ff.cnt == 32'h0) begin
          nxt_st.st = h_bits;
          nxt_st.sclk = 1'b0;
          nxt_st.cnt = 32'(sclk_half);
        end
      end
      h_tail: begin
        if (st_ff.gap != 32'h0) begin
          nxt_st.gap = st_ff.gap - 32'h1;
        end
        if (st_ff.cnt == 32'h0) begin
          nxt_st.ncs_n = 1'b1;
          nxt_st.st = h_gap;
          nxt_st.done = 1'b1;
        end
      end
      h_gap: begin
        // spacing counted from last rising edge, longest case held
        if (st_ff.gap != 32'h0) begin
          nxt_st.gap = st_ff.gap - 32'h1;
        end else begin
          nxt_st.st = h_idle;
          nxt_st.busy = 1'b0;
        end
      end
      default: begin
        nxt_st.st = h_idle;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_ff <= '0;
      st_ff.st <= h_idle;
      st_ff.sclk <= 1'b1;
      st_ff.ncs_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bus.sclk = st_ff.sclk;
  assign bus.mosi = st_ff.mosi;
  assign bus.ncs_n = st_ff.ncs_n;
  assign busy = st_ff.busy;
  assign done = st_ff.done;
  assign rd_data = st_ff.rx;
endmodule : sspt_host

// ### test/sspt_checker.sv
// concurrent checks on the serial link between host and sensor ends
`timescale 1ns/10ps
module sspt_checker (
  input wire logic mclk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic ncs_n,
  input wire logic miso_out,
  input wire logic miso_oe_n
);
  import sspt_pkg::*;
  logic [15:0] sel_c, rise_c, fall_c;
  logic [4:0] nbit;
  logic sclk_q, wr_ff;
  wire rise = sclk && !sclk_q;
  wire fall = !sclk && sclk_q;
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (srst);
  //////////////////////////////////////////////////////////////////////
  // saturating counts since select and clock edges; wide enough for 4000
  always_ff @(posedge mclk) begin
    sclk_q <= sclk;
    sel_c <= ncs_n ? 16'h0 : sel_c + {15'h0, ~&sel_c};
    rise_c <= (srst || rise) ? 16'h0 : rise_c + {15'h0, ~&rise_c};
    fall_c <= (srst || fall) ? 16'h0 : fall_c + {15'h0, ~&fall_c};
    nbit <= ncs_n ? 5'h0 : nbit + {4'h0, rise};
    wr_ff <= (rise && nbit == 5'h0) ? mosi : wr_ff;
  end
  //////////////////////////////////////////////////////////////////////
  // properties, counts taken as cycles between the edges
  property p_quiet; ncs_n && $past(ncs_n, 4) |-> miso_oe_n; endproperty
  a_quiet: assert property (p_quiet)
    else $error("output driven while idle");
  property p_drive; $fell(ncs_n) |-> ##[1:6] !miso_oe_n; endproperty
  a_drive: assert property (p_drive)
    else $error("output not driven after select");
  property p_start; $fell(sclk) |-> !ncs_n; endproperty
  a_start: assert property (p_start)
    else $error("clock moved while idle");
  property p_lead; $fell(sclk) && nbit == 5'h0 |-> sel_c >= cyc_ncs_sclk;
  endproperty
  a_lead: assert property (p_lead)
    else $error("first fall too soon after select");
  property p_srad;
    $fell(sclk) && nbit == 5'h8 && !wr_ff |-> rise_c >= cyc_srad - 1;
  endproperty
  a_srad: assert property (p_srad)
    else $error("read data clock too soon");
  property p_rd_tail; $rose(ncs_n) |-> rise_c >= cyc_sclk_ncs_rd - 1;
  endproperty
  a_rd_tail: assert property (p_rd_tail)
    else $error("select rose too soon");
  property p_wr_tail;
    $rose(ncs_n) && wr_ff |-> rise_c >= cyc_sclk_ncs_wr - 1;
  endproperty
  a_wr_tail: assert property (p_wr_tail)
    else $error("select rose too soon after write");
  property p_hold;
    !miso_oe_n && !$past(miso_oe_n) && nbit >= 5'h8 && $changed(miso_out)
      |-> fall_c <= 16'h8;
  endproperty
  a_hold: assert property (p_hold)
    else $error("output changed away from falling edge");
  property p_frame; $rose(ncs_n) |-> nbit == 5'h10; endproperty
  a_frame: assert property (p_frame)
    else $error("frame not two bytes");
  // main traffic kinds
  c_write: cover property ($rose(ncs_n) && wr_ff);
  c_read: cover property ($rose(ncs_n) && !wr_ff);
  c_data: cover property ($fell(sclk) && !miso_oe_n && nbit > 5'h8);
endmodule : sspt_checker

// ### test/sensor_serial_slave_port_tb.sv
// bench: host and sensor ends joined, plus a sensor driven by the bench
`timescale 1ns/10ps
module sensor_serial_slave_port_tb;
  import sspt_pkg::*;
  localparam int unsigned mot_c = 300;
  localparam int unsigned pd_c = 200;
  localparam int unsigned wake_c = 500;
  localparam int unsigned wake_hi = wake_c * 11 / 10; // 55 over 50 ms
  logic mclk, srst, req, req_wr, busy, done, wr_stb, wr_stb_b;
  logic motion_valid, low_power, mv_q, lp_q;
  logic [6:0] req_addr, wr_addr, wr_addr_b;
  logic [7:0] req_data, rd_data, wr_data, wr_data_b;
  logic [31:0] seed;
  int errors, samples_checked, stb_n, stb_b, since, mv_at, lp_at;
  int mem [128];
  sspt_if bus();
  sspt_if bus_b();
  sspt_host u_sspt_host (.mclk(mclk), .srst(srst), .bus(bus), .req(req),
    .req_wr(req_wr), .req_addr(req_addr), .req_data(req_data), .busy(busy),
    .done(done), .rd_data(rd_data));
  sspt_sensor #(.mot_rst_cyc(mot_c), .pd_cyc(pd_c), .wake_cyc(wake_c))
    u_sspt_sensor (.mclk(mclk), .srst(srst), .bus(bus), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_stb(wr_stb), .motion_valid(motion_valid),
    .low_power(low_power));
  // second sensor faces the bench so that faults can be injected
  sspt_sensor #(.mot_rst_cyc(mot_c), .pd_cyc(pd_c), .wake_cyc(wake_c))
    u_sspt_sensor_b (.mclk(mclk), .srst(srst), .bus(bus_b),
    .wr_addr(wr_addr_b), .wr_data(wr_data_b), .wr_stb(wr_stb_b),
    .motion_valid(), .low_power());
  sspt_checker u_sspt_checker (.mclk(mclk), .srst(srst), .sclk(bus.sclk),
    .mosi(bus.mosi), .ncs_n(bus.ncs_n), .miso_out(bus.miso_out),
    .miso_oe_n(bus.miso_oe_n));
  //////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // strobe counts and settle times in cycles after the last write strobe
  always @(posedge mclk) begin
    since <= wr_stb ? 0 : since + 1;
    mv_q <= motion_valid;
    lp_q <= low_power;
    if (motion_valid && !mv_q) mv_at <= since;
    if (low_power && !lp_q) lp_at <= since;
    if (wr_stb) stb_n <= stb_n + 1;
    if (wr_stb_b) stb_b <= stb_b + 1;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  // one framed host transfer, compared with the register model
  task automatic host_op(input logic w, input logic [6:0] a,
    input logic [7:0] d);
    int n;
    int s;
    n = 0;
    s = stb_n;
    while (busy !== 1'b0) @(negedge mclk);
    @(posedge mclk);
    req <= 1'b1;
    req_wr <= w;
    req_addr <= a;
    req_data <= d;
    @(posedge mclk);
    req <= 1'b0;
    while (done !== 1'b1 && n < 30000) begin
      @(negedge mclk);
      n++;
    end
    check(16'(n < 30000), 16'h1);
    check({15'h0, busy}, 16'h1);
    check(16'(stb_n - s), 16'(w));
    if (w) begin
      check({9'h0, wr_addr}, {9'h0, a});
      check({8'h0, wr_data}, {8'h0, d});
      mem[a] = d;
    end else check({8'h0, rd_data}, 16'(mem[a]));
  endtask : host_op
  // one bit on the bench-driven port, 80 ns clock period
  task automatic bit_b(input logic b);
    bus_b.sclk <= 1'b0;
    bus_b.mosi <= b;
    repeat (8) @(posedge mclk);
    bus_b.sclk <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask : bit_b
  task automatic frame_b(input logic [15:0] v, input int nb);
    @(posedge mclk);
    bus_b.ncs_n <= 1'b0;
    repeat (32) @(posedge mclk);
    for (int i = 15; i > 15 - nb; i--) bit_b(v[i]);
  endtask : frame_b
  task automatic results;
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results
  //////////////////////////////////////////////////////////////////////
  initial begin
    logic [6:0] a;
    srst = 1'b1;
    req = 1'b0;
    req_wr = 1'b0;
    req_addr = 7'h0;
    req_data = 8'h0;
    bus_b.sclk = 1'b1;
    bus_b.mosi = 1'b0;
    bus_b.ncs_n = 1'b1;
    seed = 32'h7ca5601e;
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    // random write, read back, random read; control addresses avoided for the write
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      a = seed[6:0];
      if (a == reg_pwr_ctl || a == reg_reset) a = a ^ 7'h40;
      host_op(1'b1, a, seed[15:8]);
      host_op(1'b0, a, seed[23:16]);
      host_op(1'b0, seed[30:24], seed[31:24]);
    end
    // reset key from normal run clears registers and resettles motion
    host_op(1'b1, reg_reset, reset_key);
    mem = '{default: 0};
    check(16'(mv_at > 0 && mv_at <= mot_c + 4), 16'h1);
    host_op(1'b0, a, 8'h00);
    // power down, then wake with the reset key
    host_op(1'b1, reg_pwr_ctl, 8'h02);
    check({15'h0, low_power}, 16'h1);
    check(16'(lp_at <= pd_c + 4), 16'h1);
    host_op(1'b1, reg_reset, reset_key);
    mem = '{default: 0};
    check(16'(mv_at >= wake_c - 2 && mv_at <= wake_hi), 16'h1);
    check({15'h0, low_power}, 16'h0);
    host_op(1'b0, reg_pwr_ctl, 8'h00);
    // idle traffic ignored, abort mid address, then a clean write
    for (int i = 0; i < 16; i++) bit_b(seed[i]);
    @(negedge mclk);
    check({15'h0, bus_b.miso_oe_n}, 16'h1);
    frame_b(16'hffff, 5);
    bus_b.ncs_n <= 1'b1;
    repeat (6000) @(posedge mclk);
    @(negedge mclk);
    check({15'h0, bus_b.miso_oe_n}, 16'h1);
    check(16'(stb_b), 16'h0);
    frame_b({1'b1, 7'h15, 8'hc3}, 16);
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    check(16'(stb_b), 16'h1);
    check({1'b0, wr_addr_b, wr_data_b}, 16'h15c3);
    repeat (4000) @(posedge mclk);
    bus_b.ncs_n <= 1'b1;
    results();
  end
  // hang guard, generous over the expected run of about 72k cycles
  initial begin
    #450000;
    errors++;
    results();
  end
endmodule : sensor_serial_slave_port_tb
